/* File: core/gcb_global_control.sv */
// Global control register bank with serial control port and sync-pin logic
//
// Operation
// - Bit 5 enables radio reseeding of frame reference
// - Bit 2 enables internal frame-reference timer
// - Bit 1 is second loop master enable
// - Bit 0 is first loop master enable
// - Pair field bit n enables channels 2n, 2n+1
// - Sync mode 00 ignores pin; 01 syncs
// - Sync mode 10 pin requests pulse generator
// - Mode 11: alarm gives sync, else pulse
// - Mode bit 5 makes input one oscillator
// - Mode bit 4 makes input zero sync
// - Reference path bit k enables input k
// - Scratchpad stores and returns value, no effect
// - Suppress bit 0 clear: sync up divider at lock
// - Suppress bit 0 set: no sync at lock
module gcb_global_control #(
    parameter int CHANNELS = 14,
    parameter int REF_INPUTS = 4
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Serial control port
    input wire logic SPI_SCLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_SDI,
    output logic SPI_SDO,
    output logic SPI_SDO_OE,
    // Sync pin
    input wire logic SYNC_PIN,
    // Status from the clock core
    input wire logic ALARM_EVENT,
    input wire logic SECOND_LOOP_LOCKED,
    // Loop and timing controls
    output logic FIRST_LOOP_ENABLE,
    output logic SECOND_LOOP_ENABLE,
    output logic SYSREF_TIMER_ENABLE,
    output logic RADIO_RESEED_ENABLE,
    output logic OSC_INTERNAL_OFF,
    output logic OSC_HIGH_BAND_SEL,
    output logic OSC_LOW_BAND_SEL,
    // Channel and reference controls
    output logic [CHANNELS-1:0] CHANNEL_ENABLE,
    output logic [REF_INPUTS-1:0] REF_PATH_ENABLE,
    output logic REF_ONE_EXT_OSC,
    output logic REF_ZERO_RF_SYNC,
    // Events and alarms
    output logic ALARM_LATCHED,
    output logic SYNC_EVENT,
    output logic PULSE_GEN_REQUEST,
    output logic LOOP2_FEEDBACK_SYNC
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_HEADER,
        PH_DATA,
        PH_DONE
    } gcb_phase_t;

    localparam int PIN_COUNT = 4;
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS_N = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_SYNC = 3;

    logic [PIN_COUNT-1:0] pin_meta_q;
    logic [PIN_COUNT-1:0] pin_sync_q;
    logic [PIN_COUNT-1:0] pin_prev_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_active;
    logic sync_pin_rise;

    gcb_phase_t phase_q;
    logic [4:0] bit_cnt_q;
    logic [4:0] bit_cnt_d;
    logic [15:0] header_q;
    logic [7:0] data_q;
    logic [7:0] rd_shift_q;
    logic wr_pulse_q;

    logic [7:0] global_enable_control_q;
    logic [7:0] output_pair_enable_q;
    logic [7:0] global_mode_control_q;
    logic [7:0] alarm_clear_q;
    logic [7:0] misc_reserved_q;
    logic [7:0] scratchpad_q;
    logic [7:0] lock_sync_control_q;

    logic clear_alarms;
    logic lock_prev_q;
    gcb_pkg::gcb_sync_mode_t sync_mode;
    gcb_pkg::gcb_osc_sel_t osc_sel;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [12:0] hdr_addr(input logic [15:0] hdr);
        hdr_addr = hdr[gcb_pkg::HDR_ADDR_MSB:0];
    endfunction : hdr_addr

    function automatic logic [7:0] reg_read(input logic [12:0] addr);
        unique case (addr)
            gcb_pkg::ADDR_GLOBAL_ENABLE_CONTROL: reg_read = global_enable_control_q;
            gcb_pkg::ADDR_OUTPUT_PAIR_ENABLE: reg_read = output_pair_enable_q;
            gcb_pkg::ADDR_GLOBAL_MODE_CONTROL: reg_read = global_mode_control_q;
            gcb_pkg::ADDR_ALARM_CLEAR: reg_read = alarm_clear_q;
            gcb_pkg::ADDR_MISC_RESERVED: reg_read = misc_reserved_q;
            gcb_pkg::ADDR_SCRATCHPAD: reg_read = scratchpad_q;
            gcb_pkg::ADDR_LOCK_SYNC_CONTROL: reg_read = lock_sync_control_q;
            default: reg_read = gcb_pkg::READ_UNMAPPED;
        endcase
    endfunction : reg_read

    function automatic logic wr_hit(input logic [12:0] target);
        wr_hit = wr_pulse_q && (hdr_addr(header_q) == target);
    endfunction : wr_hit

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Every pin is asynchronous to SYS_CLK; edges are taken from stage two against stage three
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            // Idle pin levels, so no false select or edge follows reset
            pin_meta_q <= PIN_COUNT'(1 << PIN_CS_N);
            pin_sync_q <= PIN_COUNT'(1 << PIN_CS_N);
            pin_prev_q <= PIN_COUNT'(1 << PIN_CS_N);
        end
        else
        begin
            pin_meta_q <= {SYNC_PIN, SPI_SDI, SPI_CS_N, SPI_SCLK};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    assign cs_active = !pin_sync_q[PIN_CS_N];
    assign sclk_rise = pin_sync_q[PIN_SCLK] && !pin_prev_q[PIN_SCLK];
    assign sclk_fall = !pin_sync_q[PIN_SCLK] && pin_prev_q[PIN_SCLK];
    assign sync_pin_rise = pin_sync_q[PIN_SYNC] && !pin_prev_q[PIN_SYNC];
    assign bit_cnt_d = bit_cnt_q + 5'h01;

    // ------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------
    // Oversampled port: SCLK must stay well below a quarter of SYS_CLK
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            phase_q <= PH_IDLE;
            bit_cnt_q <= 5'h00;
            header_q <= 16'h0000;
            data_q <= 8'h00;
            rd_shift_q <= 8'h00;
            wr_pulse_q <= 1'b0;
        end
        else
        begin
            wr_pulse_q <= 1'b0;
            if (!cs_active)
            begin
                phase_q <= PH_IDLE;
                bit_cnt_q <= 5'h00;
            end
            else
            begin
                unique case (phase_q)
                    PH_IDLE:
                    begin
                        phase_q <= PH_HEADER;
                    end
                    PH_HEADER:
                    begin
                        if (sclk_rise)
                        begin
                            header_q <= {header_q[14:0], pin_sync_q[PIN_SDI]};
                            bit_cnt_q <= bit_cnt_d;
                            if (bit_cnt_d == gcb_pkg::HEADER_BITS)
                            begin
                                phase_q <= PH_DATA;
                                rd_shift_q <= reg_read(hdr_addr({header_q[14:0],
                                    pin_sync_q[PIN_SDI]}));
                            end
                        end
                    end
                    PH_DATA:
                    begin
                        if (sclk_rise)
                        begin
                            data_q <= {data_q[6:0], pin_sync_q[PIN_SDI]};
                            bit_cnt_q <= bit_cnt_d;
                            if (bit_cnt_d == gcb_pkg::FRAME_BITS)
                            begin
                                phase_q <= PH_DONE;
                                wr_pulse_q <= !header_q[gcb_pkg::HDR_READ_BIT];
                            end
                        end
                        else if (sclk_fall)
                        begin
                            rd_shift_q <= {rd_shift_q[6:0], 1'b0};
                        end
                    end
                    PH_DONE:
                    begin
                        // Extra clocks after one byte are ignored until CS rises
                        phase_q <= PH_DONE;
                    end
                endcase
            end
        end
    end

    // Read data leaves on falling SCLK so the host samples it on the rising edge
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            SPI_SDO <= 1'b0;
            SPI_SDO_OE <= 1'b0;
        end
        else
        begin
            SPI_SDO_OE <= cs_active && (phase_q == PH_DATA) &&
                header_q[gcb_pkg::HDR_READ_BIT];
            if (sclk_fall && phase_q == PH_DATA)
            begin
                SPI_SDO <= rd_shift_q[7];
            end
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            global_enable_control_q <= gcb_pkg::REG_RESET_VALUE;
            output_pair_enable_q <= gcb_pkg::REG_RESET_VALUE;
            global_mode_control_q <= gcb_pkg::REG_RESET_VALUE;
            alarm_clear_q <= gcb_pkg::REG_RESET_VALUE;
            misc_reserved_q <= gcb_pkg::REG_RESET_VALUE;
            scratchpad_q <= gcb_pkg::REG_RESET_VALUE;
            lock_sync_control_q <= gcb_pkg::REG_RESET_VALUE;
        end
        else
        begin
            if (wr_hit(gcb_pkg::ADDR_GLOBAL_ENABLE_CONTROL))
                global_enable_control_q <= data_q;
            if (wr_hit(gcb_pkg::ADDR_OUTPUT_PAIR_ENABLE))
                output_pair_enable_q <= data_q;
            if (wr_hit(gcb_pkg::ADDR_GLOBAL_MODE_CONTROL))
                global_mode_control_q <= data_q;
            if (wr_hit(gcb_pkg::ADDR_ALARM_CLEAR))
                alarm_clear_q <= data_q;
            if (wr_hit(gcb_pkg::ADDR_MISC_RESERVED))
                misc_reserved_q <= data_q;
            if (wr_hit(gcb_pkg::ADDR_SCRATCHPAD))
                scratchpad_q <= data_q;
            if (wr_hit(gcb_pkg::ADDR_LOCK_SYNC_CONTROL))
                lock_sync_control_q <= data_q;
        end
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    assign osc_sel = gcb_pkg::gcb_osc_sel_t'(global_enable_control_q[gcb_pkg::OSC_SELECT_MSB:
        gcb_pkg::OSC_SELECT_LSB]);

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            FIRST_LOOP_ENABLE <= 1'b0;
            SECOND_LOOP_ENABLE <= 1'b0;
            SYSREF_TIMER_ENABLE <= 1'b0;
            RADIO_RESEED_ENABLE <= 1'b0;
            OSC_INTERNAL_OFF <= 1'b0;
            OSC_HIGH_BAND_SEL <= 1'b0;
            OSC_LOW_BAND_SEL <= 1'b0;
            REF_PATH_ENABLE <= '0;
            REF_ONE_EXT_OSC <= 1'b0;
            REF_ZERO_RF_SYNC <= 1'b0;
        end
        else
        begin
            FIRST_LOOP_ENABLE <= global_enable_control_q[gcb_pkg::BIT_FIRST_LOOP_ENABLE];
            SECOND_LOOP_ENABLE <= global_enable_control_q[gcb_pkg::BIT_SECOND_LOOP_ENABLE];
            SYSREF_TIMER_ENABLE <= global_enable_control_q[gcb_pkg::BIT_SYSREF_TIMER_ENABLE];
            RADIO_RESEED_ENABLE <= global_enable_control_q[gcb_pkg::BIT_RADIO_RESEED_ENABLE];
            OSC_INTERNAL_OFF <= (osc_sel == gcb_pkg::OSC_SEL_EXTERNAL);
            OSC_HIGH_BAND_SEL <= (osc_sel == gcb_pkg::OSC_SEL_HIGH);
            OSC_LOW_BAND_SEL <= (osc_sel == gcb_pkg::OSC_SEL_LOW);
            REF_PATH_ENABLE <= global_mode_control_q[REF_INPUTS-1:0];
            REF_ONE_EXT_OSC <= global_mode_control_q[gcb_pkg::BIT_REF_ONE_EXT_OSC];
            REF_ZERO_RF_SYNC <= global_mode_control_q[gcb_pkg::BIT_REF_ZERO_RF_SYNC];
        end
    end

    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_channel
        always_ff @(posedge SYS_CLK or negedge RESET_N)
        begin
            if (!RESET_N)
                CHANNEL_ENABLE[ch] <= 1'b0;
            else
                CHANNEL_ENABLE[ch] <= output_pair_enable_q[ch / 2];
        end
    end

    // ------------------------------------------------------------
    // Alarms and sync events
    // ------------------------------------------------------------
    // clear on write of one
    assign clear_alarms = wr_hit(gcb_pkg::ADDR_ALARM_CLEAR) && data_q[gcb_pkg::BIT_CLEAR_ALARMS];

    // A new alarm in the clearing cycle survives the clear
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            ALARM_LATCHED <= 1'b0;
        else if (ALARM_EVENT)
            ALARM_LATCHED <= 1'b1;
        else if (clear_alarms)
            ALARM_LATCHED <= 1'b0;
    end

    assign sync_mode = gcb_pkg::gcb_sync_mode_t'(global_mode_control_q[gcb_pkg::SYNC_MODE_MSB:
        gcb_pkg::SYNC_MODE_LSB]);

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            SYNC_EVENT <= 1'b0;
            PULSE_GEN_REQUEST <= 1'b0;
        end
        else
        begin
            SYNC_EVENT <= 1'b0;
            PULSE_GEN_REQUEST <= 1'b0;
            if (sync_pin_rise)
            begin
                unique case (sync_mode)
                    gcb_pkg::SYNC_MODE_OFF: SYNC_EVENT <= 1'b0;
                    gcb_pkg::SYNC_MODE_EVENT: SYNC_EVENT <= 1'b1;
                    gcb_pkg::SYNC_MODE_PULSE: PULSE_GEN_REQUEST <= 1'b1;
                    gcb_pkg::SYNC_MODE_ALARM:
                    begin
                        SYNC_EVENT <= ALARM_LATCHED;
                        PULSE_GEN_REQUEST <= !ALARM_LATCHED;
                    end
                endcase
            end
        end
    end

    // Lock status comes from the same clock domain, so no synchroniser
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            lock_prev_q <= 1'b0;
            LOOP2_FEEDBACK_SYNC <= 1'b0;
        end
        else
        begin
            lock_prev_q <= SECOND_LOOP_LOCKED;
            LOOP2_FEEDBACK_SYNC <= SECOND_LOOP_LOCKED && !lock_prev_q &&
                !lock_sync_control_q[gcb_pkg::BIT_LOCK_EVENT_SUPPRESS];
        end
    end

endmodule : gcb_global_control

/* File: core/gcb_pkg.sv */
// Constants and types shared by the global control bank
package gcb_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [12:0] ADDR_GLOBAL_ENABLE_CONTROL = 13'h0003;
    localparam logic [12:0] ADDR_OUTPUT_PAIR_ENABLE = 13'h0004;
    localparam logic [12:0] ADDR_GLOBAL_MODE_CONTROL = 13'h0005;
    localparam logic [12:0] ADDR_ALARM_CLEAR = 13'h0006;
    localparam logic [12:0] ADDR_MISC_RESERVED = 13'h0007;
    localparam logic [12:0] ADDR_SCRATCHPAD = 13'h0008;
    localparam logic [12:0] ADDR_LOCK_SYNC_CONTROL = 13'h0009;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    localparam int BIT_RADIO_RESEED_ENABLE = 5;
    localparam int OSC_SELECT_LSB = 3;
    localparam int OSC_SELECT_MSB = 4;
    localparam int BIT_SYSREF_TIMER_ENABLE = 2;
    localparam int BIT_SECOND_LOOP_ENABLE = 1;
    localparam int BIT_FIRST_LOOP_ENABLE = 0;

    localparam int PAIR_FIELD_WIDTH = 7;

    localparam int SYNC_MODE_LSB = 6;
    localparam int SYNC_MODE_MSB = 7;
    localparam int BIT_REF_ONE_EXT_OSC = 5;
    localparam int BIT_REF_ZERO_RF_SYNC = 4;
    localparam int REF_PATH_WIDTH = 4;

    localparam int BIT_CLEAR_ALARMS = 0;
    localparam int BIT_LOCK_EVENT_SUPPRESS = 0;

    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam int FRAME_COUNT_WIDTH = 5;
    localparam logic [4:0] HEADER_BITS = 5'h10;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam int HDR_READ_BIT = 15;
    localparam int HDR_ADDR_MSB = 12;

    typedef enum logic [1:0] {
        SYNC_MODE_OFF = 2'h0,
        SYNC_MODE_EVENT = 2'h1,
        SYNC_MODE_PULSE = 2'h2,
        SYNC_MODE_ALARM = 2'h3
    } gcb_sync_mode_t;

    typedef enum logic [1:0] {
        OSC_SEL_EXTERNAL = 2'h0,
        OSC_SEL_HIGH = 2'h1,
        OSC_SEL_LOW = 2'h2,
        OSC_SEL_UNUSED = 2'h3
    } gcb_osc_sel_t;

endpackage : gcb_pkg

/* File: testbench/gcb_global_control_bench.sv */
// Bench for the global control bank
module gcb_global_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk, reset_n, sync_pin, alarm_event, lock_in;
    logic sclk, cs_n, sdi, sdo, sdo_oe, sdo_line;
    logic first_en, second_en, sysref_en, reseed_en, osc_off, osc_high, osc_low;
    logic [13:0] chan_en;
    logic [3:0] ref_en;
    logic ref_one, ref_zero, alarm_q, sync_ev, pulse_req, lock_sync;
    logic [26:0] outs;
    logic [7:0] regs [0:15];
    logic [7:0] rd;
    logic [15:0] corner [12] = '{16'h0327, 16'h032E, 16'h0330, 16'h0319, 16'h0401, 16'h0440,
        16'h047F, 16'h0480, 16'h0530, 16'h050F, 16'h05C0, 16'h0901};
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n_sync = 0, n_pulse = 0, n_lock = 0;

    // Pull-up on the read data line
    assign sdo_line = sdo_oe ? sdo : 1'b1;
    assign outs = {first_en, second_en, sysref_en, reseed_en, osc_off, osc_high, osc_low,
        chan_en, ref_en, ref_one, ref_zero};

    gcb_global_control u_gcb_global_control (
        .SYS_CLK(sys_clk), .RESET_N(reset_n), .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_SDI(sdi),
        .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe), .SYNC_PIN(sync_pin), .ALARM_EVENT(alarm_event),
        .SECOND_LOOP_LOCKED(lock_in), .FIRST_LOOP_ENABLE(first_en),
        .SECOND_LOOP_ENABLE(second_en), .SYSREF_TIMER_ENABLE(sysref_en),
        .RADIO_RESEED_ENABLE(reseed_en), .OSC_INTERNAL_OFF(osc_off),
        .OSC_HIGH_BAND_SEL(osc_high), .OSC_LOW_BAND_SEL(osc_low), .CHANNEL_ENABLE(chan_en),
        .REF_PATH_ENABLE(ref_en), .REF_ONE_EXT_OSC(ref_one), .REF_ZERO_RF_SYNC(ref_zero),
        .ALARM_LATCHED(alarm_q), .SYNC_EVENT(sync_ev), .PULSE_GEN_REQUEST(pulse_req),
        .LOOP2_FEEDBACK_SYNC(lock_sync)
    );

    gcb_host_model u_gcb_host_model (
        .clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_line)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Event counting and timeout
    // ----------------------------------------
    // ~81 frames of ~313 cycles; ceiling is over twice that
    always @(posedge sys_clk)
    begin
        cycles++;
        n_sync += (sync_ev === 1'b1);
        n_pulse += (pulse_req === 1'b1);
        n_lock += (lock_sync === 1'b1);
        if (cycles == 60000)
        begin
            num_errors++;
            conclude();
        end
    end

    // ----------------------------------------
    // Expectations, compares and access tasks
    // ----------------------------------------
    function automatic logic [26:0] exp_outs(input logic [7:0] e, p, m);
        logic [13:0] ch;
        for (int c = 0; c < 14; c++) ch[c] = p[c / 2];
        return {e[0], e[1], e[2], e[5], e[4:3] == 2'b00, e[4:3] == 2'b01, e[4:3] == 2'b10,
            ch, m[3:0], m[5], m[4]};
    endfunction : exp_outs

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_outs(input logic [26:0] got, input logic [26:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t outs=%h exp=%h", $time, got, exp);
        end
    endtask : check_outs

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        u_gcb_host_model.xfer(1'b0, a, d, 24, rd);
        if (a < 13'h0010) regs[a[3:0]] = d;
    endtask : wr

    task automatic rdchk(input logic [12:0] a);
        logic [7:0] e = (a >= 13'h0003 && a <= 13'h0009) ? regs[a[3:0]] : 8'h00;
        u_gcb_host_model.xfer(1'b1, a, 8'h00, 24, rd);
        check_byte(rd, e);
    endtask : rdchk

    task automatic wrchk(input logic [12:0] a, input logic [7:0] d);
        wr(a, d);
        rdchk(a);
        check_outs(outs, exp_outs(regs[3], regs[4], regs[5]));
    endtask : wrchk

    task automatic alarm_pulse();
        alarm_event <= 1'b1;
        @(posedge sys_clk);
        alarm_event <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask : alarm_pulse

    task automatic pin_event(input logic es, input logic ep);
        int s0 = n_sync, p0 = n_pulse;
        @(posedge sys_clk);
        sync_pin <= 1'b1;
        repeat (6) @(posedge sys_clk);
        sync_pin <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check_byte(8'(n_sync - s0), {7'h00, es});
        check_byte(8'(n_pulse - p0), {7'h00, ep});
    endtask : pin_event

    task automatic conclude();
        $display("Checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        int l0;
        reset_n = 1'b0;
        sync_pin = 1'b0;
        alarm_event = 1'b0;
        lock_in = 1'b0;
        regs = '{default: 8'h00};
        void'($urandom(68));
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        for (int a = 3; a < 10; a++) rdchk(13'(a));
        check_outs(outs, exp_outs(8'h00, 8'h00, 8'h00));
        foreach (corner[k]) wrchk(13'(corner[k][15:8]), corner[k][7:0]);
        for (int n = 0; n < 14; n++) wrchk(13'(3 + $urandom % 7), 8'($urandom));
        // Unmapped places read zero
        wr(13'h000A, 8'h5A);
        rdchk(13'h000A);
        rdchk(13'h1FFF);
        // Aborted frames write nothing
        u_gcb_host_model.xfer(1'b0, gcb_pkg::ADDR_SCRATCHPAD, 8'hC3, 12, rd);
        u_gcb_host_model.xfer(1'b0, gcb_pkg::ADDR_SCRATCHPAD, 8'h3C, 20, rd);
        rdchk(gcb_pkg::ADDR_SCRATCHPAD);
        alarm_pulse();
        check_byte({7'h00, alarm_q}, 8'h01);
        wr(gcb_pkg::ADDR_ALARM_CLEAR, 8'hFE);
        check_byte({7'h00, alarm_q}, 8'h01);
        wr(gcb_pkg::ADDR_ALARM_CLEAR, 8'h01);
        check_byte({7'h00, alarm_q}, 8'h00);
        for (int m = 0; m < 8; m++)
        begin
            if (m[0]) alarm_pulse();
            else wr(gcb_pkg::ADDR_ALARM_CLEAR, 8'h01);
            wr(gcb_pkg::ADDR_GLOBAL_MODE_CONTROL, {m[2:1], 6'(m * 5)});
            pin_event(m[2:1] == 2'b01 || (m[2:1] == 2'b11 && m[0]),
                m[2:1] == 2'b10 || (m[2:1] == 2'b11 && !m[0]));
        end
        for (int s = 0; s < 2; s++)
        begin
            wr(gcb_pkg::ADDR_LOCK_SYNC_CONTROL, {7'($urandom), s[0]});
            l0 = n_lock;
            lock_in <= 1'b1;
            repeat (4) @(posedge sys_clk);
            lock_in <= 1'b0;
            repeat (2) @(posedge sys_clk);
            check_byte(8'(n_lock - l0), {7'h00, !s[0]});
        end
        conclude();
    end
endmodule : gcb_global_control_bench

/* File: testbench/gcb_global_control_checker.sv */
// Port assertions for the global control bank
module gcb_global_control_checker #(
    parameter int CHANNELS = 14,
    parameter int REF_INPUTS = 4
) (
    // Clock, reset and inputs
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic SPI_CS_N,
    input wire logic SYNC_PIN,
    input wire logic ALARM_EVENT,
    input wire logic SECOND_LOOP_LOCKED,
    // Observed outputs
    input wire logic SPI_SDO_OE,
    input wire logic FIRST_LOOP_ENABLE,
    input wire logic SECOND_LOOP_ENABLE,
    input wire logic SYSREF_TIMER_ENABLE,
    input wire logic RADIO_RESEED_ENABLE,
    input wire logic OSC_INTERNAL_OFF,
    input wire logic OSC_HIGH_BAND_SEL,
    input wire logic OSC_LOW_BAND_SEL,
    input wire logic [CHANNELS-1:0] CHANNEL_ENABLE,
    input wire logic [REF_INPUTS-1:0] REF_PATH_ENABLE,
    input wire logic REF_ONE_EXT_OSC,
    input wire logic REF_ZERO_RF_SYNC,
    input wire logic ALARM_LATCHED,
    input wire logic SYNC_EVENT,
    input wire logic PULSE_GEN_REQUEST,
    input wire logic LOOP2_FEEDBACK_SYNC
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    // Cycles since the port was last selected
    logic [3:0] idle_q;
    logic pairs_ok;
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N) idle_q <= 4'h0;
        else if (!SPI_CS_N) idle_q <= 4'h0;
        else if (idle_q != 4'hF) idle_q <= idle_q + 4'h1;
    end
    always_comb
    begin
        pairs_ok = 1'b1;
        for (int c = 0; c + 1 < CHANNELS; c += 2)
            pairs_ok &= (CHANNEL_ENABLE[c] == CHANNEL_ENABLE[c + 1]);
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_OSC_ONEHOT:
    assert property ($onehot0({OSC_INTERNAL_OFF, OSC_HIGH_BAND_SEL, OSC_LOW_BAND_SEL}))
        else $error("Oscillator selects overlap");
    AST_CHAN_PAIRS:
    assert property (pairs_ok) else $error("Channel pair enables differ");
    AST_LOOP_CFG_QUIET:
    assert property ($changed({FIRST_LOOP_ENABLE, SECOND_LOOP_ENABLE, SYSREF_TIMER_ENABLE,
        RADIO_RESEED_ENABLE, OSC_HIGH_BAND_SEL, OSC_LOW_BAND_SEL}) |-> idle_q < 4'hA)
        else $error("Loop setting moved idle");
    AST_PATH_CFG_QUIET:
    assert property ($changed({CHANNEL_ENABLE, REF_PATH_ENABLE, REF_ONE_EXT_OSC,
        REF_ZERO_RF_SYNC}) |-> idle_q < 4'hA) else $error("Path setting moved idle");
    AST_SYNC_TIMING:
    assert property (SYNC_EVENT |-> $past(SYNC_PIN, 3) && !$past(SYNC_PIN, 6))
        else $error("Sync without pin edge");
    AST_PULSE_TIMING:
    assert property (PULSE_GEN_REQUEST |-> $past(SYNC_PIN, 3) && !$past(SYNC_PIN, 6))
        else $error("Pulse without pin edge");
    AST_EVENT_EXCL:
    assert property (!(SYNC_EVENT && PULSE_GEN_REQUEST)) else $error("Sync and pulse together");
    AST_LOCK_SYNC:
    assert property (LOOP2_FEEDBACK_SYNC |-> $past(SECOND_LOOP_LOCKED)
        && !$past(SECOND_LOOP_LOCKED, 2)) else $error("Lock sync without a lock edge");
    AST_ALARM_SET:
    assert property (ALARM_EVENT |=> ALARM_LATCHED) else $error("Alarm not latched");
    AST_ALARM_CLEAR:
    assert property ($fell(ALARM_LATCHED) |-> idle_q < 4'hA && !$past(ALARM_EVENT))
        else $error("Alarm cleared without a write");
    AST_SDO_FRAME:
    assert property (SPI_SDO_OE |-> idle_q < 4'h5) else $error("Read data driven while idle");
endmodule : gcb_global_control_checker

bind gcb_global_control gcb_global_control_checker #(.CHANNELS(CHANNELS),
    .REF_INPUTS(REF_INPUTS)) u_gcb_global_control_checker (
    .SYS_CLK, .RESET_N, .SPI_CS_N, .SYNC_PIN, .ALARM_EVENT, .SECOND_LOOP_LOCKED, .SPI_SDO_OE,
    .FIRST_LOOP_ENABLE, .SECOND_LOOP_ENABLE, .SYSREF_TIMER_ENABLE, .RADIO_RESEED_ENABLE,
    .OSC_INTERNAL_OFF, .OSC_HIGH_BAND_SEL, .OSC_LOW_BAND_SEL, .CHANNEL_ENABLE,
    .REF_PATH_ENABLE, .REF_ONE_EXT_OSC, .REF_ZERO_RF_SYNC, .ALARM_LATCHED, .SYNC_EVENT,
    .PULSE_GEN_REQUEST, .LOOP2_FEEDBACK_SYNC
);

/* File: testbench/gcb_host_model.sv */
// Host model for the serial port
module gcb_host_model (
    // Clock
    input wire logic clk,
    // Serial port
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;

    // Six cycles per level: margin over the four-cycle minimum
    localparam int HALF = 6;

    initial {sclk, cs_n, sdi} = 3'b010;

    // One frame; under 24 bits aborts it
    task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wdata,
        input int nbits, output logic [7:0] rdata);
        logic [23:0] frame = {rd, 2'b00, addr, wdata};
        rdata = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (HALF) @(posedge clk);
        for (int i = 23; i >= 24 - nbits; i--)
        begin
            sdi <= frame[i];
            repeat (HALF) @(posedge clk);
            sclk <= 1'b1;
            if (i < 8) rdata[i] = sdo;
            repeat (HALF) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        cs_n <= 1'b1;
        // Deselected data line carries no meaning
        sdi <= ~sdi;
        repeat (2 * HALF) @(posedge clk);
    endtask : xfer
endmodule : gcb_host_model
